// [rtl/lpc_pkg.sv]
package lpc_pkg;

    // Reference clock and derived link clock.
    localparam int REF_PERIOD_NS = 100;
    localparam int CK_PERIOD_NS  = 800;
    localparam int CK_HALF_CYC   = CK_PERIOD_NS / (2 * REF_PERIOD_NS);
    localparam int CKDIV_W       = 4;

    // Timing figures in nanoseconds; the power-down limit is a count of refresh intervals.
    localparam int T_CKE_NS        = 5;
    localparam int T_XP_NS         = 6;
    localparam int T_CPDED_NS      = 20;
    localparam int T_MPX_LH_MIN_NS = 12;
    localparam int T_MPX_LH_GAP_NS = 10;
    localparam int T_XS_NS         = 1000;
    localparam int T_REFI_NS       = 7800;
    localparam int PD_REFI_LIMIT   = 9;

    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_max(input int ns);
        int c;
        c = ns / REF_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int TMR_W        = 10;
    localparam int CKE_CYC_I    = cyc_min(T_CKE_NS);
    localparam int XP_CYC_I     = cyc_min(T_XP_NS);
    localparam int PDX_CYC_I    = (XP_CYC_I > CKE_CYC_I) ? XP_CYC_I : CKE_CYC_I;
    localparam int LH_MAX_CYC_I = cyc_max(T_XS_NS - T_MPX_LH_GAP_NS);
    localparam int PD_LIM_CYC_I = cyc_max(PD_REFI_LIMIT * T_REFI_NS);
    localparam int CK_CYC_I     = 2 * CK_HALF_CYC;

    localparam logic [TMR_W-1:0] CKE_CYC    = TMR_W'(CKE_CYC_I);
    localparam logic [TMR_W-1:0] PDX_CYC    = TMR_W'(PDX_CYC_I);
    localparam logic [TMR_W-1:0] CPDED_CYC  = TMR_W'(cyc_min(T_CPDED_NS));
    localparam logic [TMR_W-1:0] LH_MIN_CYC = TMR_W'(cyc_min(T_MPX_LH_MIN_NS));
    localparam logic [TMR_W-1:0] XS_CYC     = TMR_W'(cyc_min(T_XS_NS));
    // Leaves room for the exit to begin on a link clock fall before the limit.
    localparam logic [TMR_W-1:0] PD_MAX_CYC = TMR_W'(PD_LIM_CYC_I - 3 * CK_CYC_I);

    // Register byte offsets.
    localparam logic [3:0] ADDR_CMD    = 4'h0;
    localparam logic [3:0] ADDR_MODE   = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // Mode register fields.
    localparam int MODE_W       = 8;
    localparam int MB_RATE_LO   = 0;
    localparam int MB_TERM_OFF  = 2;
    localparam int MB_RTT_NOM   = 3;
    localparam int MB_PARITY    = 4;
    localparam int MB_CAL       = 5;
    localparam int MB_SHARED    = 6;
    localparam int MB_RESET_REL = 7;
    localparam logic [MODE_W-1:0] MODE_RST = 8'h00;

    // Status register fields.
    localparam int SB_ERR_REF  = 16;
    localparam int SB_ERR_PDTO = 17;
    localparam int SB_PEND_LO  = 18;
    localparam int SB_CKE      = 24;

    typedef enum logic [1:0] {
        RATE_NORMAL   = 2'h0,
        RATE_REDUCED  = 2'h1,
        RATE_EXTENDED = 2'h2,
        RATE_AUTO     = 2'h3
    } lpc_rate_t;

    typedef enum logic [2:0] {
        CMD_NONE     = 3'h0,
        CMD_PD_ENTER = 3'h1,
        CMD_PD_EXIT  = 3'h2,
        CMD_SR_ENTER = 3'h3,
        CMD_SR_NOPX  = 3'h4
    } lpc_cmd_t;

    localparam int ST_W = 9;
    typedef enum logic [ST_W-1:0] {
        ST_IDLE = 9'h001,
        ST_PDE  = 9'h002,
        ST_PD   = 9'h004,
        ST_PDX  = 9'h008,
        ST_SRE  = 9'h010,
        ST_SR   = 9'h020,
        ST_SRXS = 9'h040,
        ST_SRXL = 9'h080,
        ST_SRXW = 9'h100
    } lpc_state_t;

endpackage

// [rtl/lpc_ck_if.sv]
`timescale 1ns/1ps
interface lpc_ck_if;
    logic ck;
    logic fall;
    modport src (output ck, output fall);
    modport snk (input ck, input fall);
endinterface

// [rtl/lpc_ckgen.sv]
`timescale 1ns/1ps
module lpc_ckgen
    import lpc_pkg::*;
#(
    parameter int HALF = CK_HALF_CYC
)(
    input  wire logic i_ref_clk,
    input  wire logic i_rst_b,
    lpc_ck_if.src     ckif
);

    typedef struct packed {
        logic [CKDIV_W-1:0] cnt;
        logic               ck;
        logic               fall;
    } lpc_ckgen_t;

    lpc_ckgen_t r;
    lpc_ckgen_t n;

    // The fall pulse marks the cycle in which the link clock has just gone low.
    always_comb begin
        n      = r;
        n.fall = 1'b0;
        if (r.cnt == CKDIV_W'(HALF - 1)) begin
            n.cnt  = '0;
            n.ck   = ~r.ck;
            n.fall = r.ck;
        end else begin
            n.cnt = r.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign ckif.ck   = r.ck;
    assign ckif.fall = r.fall;

endmodule

// [rtl/lpc_host.sv]
`timescale 1ns/1ps
module lpc_host
    import lpc_pkg::*;
#(
    parameter int CK_HALF = CK_HALF_CYC
)(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_dev_busy,
    output logic             o_ck,
    output logic             o_cke,
    output logic             o_cs_n,
    output logic             o_act_n,
    output logic             o_ras_n,
    output logic             o_cas_n,
    output logic             o_we_n,
    output logic             o_reset_n,
    output logic             o_term,
    output logic             o_term_oe_n,
    output logic             o_rate_a6,
    output logic             o_rate_a7,
    output logic             o_auto_rate
);

    typedef struct packed {
        lpc_state_t         st;
        logic [TMR_W-1:0]   tmr;
        logic [TMR_W-1:0]   pdtmr;
        logic               cke;
        logic               cs_n;
        logic               act_n;
        logic               ras_n;
        logic               cas_n;
        logic               we_n;
        logic               term_oe_n;
        logic [MODE_W-1:0]  mode;
        logic [1:0]         lat_pc;
        lpc_cmd_t           pend;
        logic               err_ref;
        logic               err_pdto;
        logic               ack;
        logic [31:0]        rdata;
    } lpc_main_t;

    localparam lpc_main_t LPC_RST = '{
        st:     ST_IDLE,
        cke:    1'b1,
        cs_n:   1'b1,
        act_n:  1'b1,
        ras_n:  1'b1,
        cas_n:  1'b1,
        we_n:   1'b1,
        mode:   MODE_RST,
        pend:   CMD_NONE,
        default: '0
    };

    lpc_ck_if ckif ();

    lpc_ckgen #(
        .HALF (CK_HALF)
    ) u_ckgen (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .ckif      (ckif)
    );

    lpc_main_t   r;
    lpc_main_t   n;
    logic        req;
    logic        wr_do;
    logic        ref_set;
    logic        pdto_set;
    logic        in_sr;
    logic        in_pd;
    logic        cmd_ok;
    lpc_cmd_t    wcmd;
    logic [31:0] rd;

    assign req   = i_avs_read | i_avs_write;
    assign wr_do = i_avs_write & r.ack;
    assign in_sr = (r.st == ST_SRE) | (r.st == ST_SR) | (r.st == ST_SRXS);
    assign in_pd = (r.st == ST_PDE) | (r.st == ST_PD);
    assign wcmd  = lpc_cmd_t'(i_avs_writedata[2:0]);

    // Commands are only taken in a state that can act on them.
    always_comb begin
        cmd_ok = 1'b0;
        case (wcmd)
            CMD_PD_ENTER, CMD_SR_ENTER: begin
                cmd_ok = (r.st == ST_IDLE) & (r.pend == CMD_NONE);
            end
            CMD_PD_EXIT: begin
                cmd_ok = in_pd & (r.pend == CMD_NONE);
            end
            CMD_SR_NOPX: begin
                cmd_ok = (r.st == ST_SR) & (r.pend == CMD_NONE)
                       & (r.lat_pc == 2'h0) & r.mode[MB_SHARED];
            end
            default: begin
                cmd_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        rd = '0;
        case (i_avs_address)
            ADDR_CMD: begin
                rd[2:0] = r.pend;
            end
            ADDR_MODE: begin
                rd[MODE_W-1:0] = r.mode;
            end
            ADDR_STATUS: begin
                rd[ST_W-1:0]              = r.st;
                rd[SB_ERR_REF]            = r.err_ref;
                rd[SB_ERR_PDTO]           = r.err_pdto;
                rd[SB_PEND_LO +: 3]       = r.pend;
                rd[SB_CKE]                = r.cke;
            end
            default: begin
                rd = '0;
            end
        endcase
    end

    always_comb begin
        n        = r;
        ref_set  = 1'b0;
        pdto_set = 1'b0;
        n.ack    = req & ~r.ack;
        if (req & ~r.ack) begin
            n.rdata = rd;
        end
        if (r.tmr != '0) begin
            n.tmr = r.tmr - 1'b1;
        end
        if ((r.st == ST_PD) && (r.pdtmr != '0)) begin
            n.pdtmr = r.pdtmr - 1'b1;
        end

        if (wr_do) begin
            case (i_avs_address)
                ADDR_CMD: begin
                    if (cmd_ok) begin
                        n.pend = wcmd;
                    end else begin
                        ref_set = 1'b1;
                    end
                end
                ADDR_MODE: begin
                    n.mode = i_avs_writedata[MODE_W-1:0];
                    // The rate chosen at refresh entry may not move until exit.
                    if (in_sr && (i_avs_writedata[1:0] != r.mode[1:0])) begin
                        n.mode[1:0] = r.mode[1:0];
                        ref_set     = 1'b1;
                    end
                end
                ADDR_STATUS: begin
                    if (i_avs_writedata[SB_ERR_REF]) begin
                        n.err_ref = 1'b0;
                    end
                    if (i_avs_writedata[SB_ERR_PDTO]) begin
                        n.err_pdto = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Pins other than the reset and rate pins move only on the falling link clock so the memory sees them settled.
        if (ckif.fall) begin
            case (r.st)
                ST_IDLE: begin
                    if ((r.pend == CMD_PD_ENTER) && !i_dev_busy) begin
                        n.cke  = 1'b0;
                        n.cs_n = 1'b1;
                        n.tmr  = CPDED_CYC;
                        n.pend = CMD_NONE;
                        n.st   = ST_PDE;
                    end else if ((r.pend == CMD_SR_ENTER) && !i_dev_busy) begin
                        n.cke    = 1'b0;
                        n.cs_n   = 1'b0;
                        n.ras_n  = 1'b0;
                        n.cas_n  = 1'b0;
                        n.lat_pc = {r.mode[MB_PARITY], r.mode[MB_CAL]};
                        n.pend   = CMD_NONE;
                        n.st     = ST_SRE;
                    end
                end
                ST_PDE: begin
                    if (r.tmr == '0) begin
                        n.term_oe_n = r.mode[MB_TERM_OFF];
                        n.tmr      = CKE_CYC;
                        n.pdtmr    = PD_MAX_CYC;
                        n.st       = ST_PD;
                    end
                end
                ST_PD: begin
                    if ((r.tmr == '0) && ((r.pend == CMD_PD_EXIT) || (r.pdtmr == '0))) begin
                        pdto_set   = (r.pend != CMD_PD_EXIT);
                        n.cke      = 1'b1;
                        n.term_oe_n = 1'b0;
                        n.tmr      = PDX_CYC;
                        n.st       = ST_PDX;
                    end
                end
                ST_PDX: begin
                    if (r.tmr == '0) begin
                        n.pend = CMD_NONE;
                        n.st   = ST_IDLE;
                    end
                end
                ST_SRE: begin
                    n.cs_n  = 1'b1;
                    n.ras_n = 1'b1;
                    n.cas_n = 1'b1;
                    n.tmr   = CKE_CYC;
                    n.st    = ST_SR;
                end
                ST_SR: begin
                    if ((r.tmr == '0) && (r.pend == CMD_SR_NOPX)) begin
                        n.cs_n = 1'b0;
                        n.pend = CMD_NONE;
                        n.st   = ST_SRXS;
                    end
                end
                ST_SRXS: begin
                    n.cke = 1'b1;
                    n.tmr = LH_MIN_CYC;
                    n.st  = ST_SRXL;
                end
                ST_SRXL: begin
                    // One link period keeps the hold inside its upper bound.
                    if (r.tmr == '0) begin
                        n.cs_n = 1'b1;
                        n.tmr  = XS_CYC;
                        n.st   = ST_SRXW;
                    end
                end
                ST_SRXW: begin
                    if (r.tmr == '0) begin
                        n.st = ST_IDLE;
                    end
                end
                default: begin
                    n = LPC_RST;
                end
            endcase
        end

        // A new event wins over a clear in the same cycle.
        n.err_ref  = n.err_ref | ref_set;
        n.err_pdto = n.err_pdto | pdto_set;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            r <= LPC_RST;
        end else begin
            r <= n;
        end
    end

    assign o_avs_waitrequest = req & ~r.ack;
    assign o_avs_readdata    = r.rdata;
    assign o_ck              = ckif.ck;
    assign o_cke             = r.cke;
    assign o_cs_n            = r.cs_n;
    assign o_act_n           = r.act_n;
    assign o_ras_n           = r.ras_n;
    assign o_cas_n           = r.cas_n;
    assign o_we_n            = r.we_n;
    assign o_term            = 1'b0;
    assign o_term_oe_n       = r.term_oe_n;
    assign o_reset_n         = r.mode[MB_RESET_REL] | in_pd | (r.st == ST_PDX);
    assign o_rate_a6         = r.mode[MB_RATE_LO];
    assign o_rate_a7         = r.mode[MB_RATE_LO + 1];
    assign o_auto_rate       = (lpc_rate_t'(r.mode[1:0]) == RATE_AUTO);

    // Checks.
    localparam int LH_LO  = 1;
    localparam int LH_HI  = LH_MAX_CYC_I;
    localparam int PD_LIM = PD_LIM_CYC_I;

    logic [TMR_W-1:0] pd_len;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || !(in_pd || r.st == ST_PDX) || r.cke) begin
            pd_len <= '0;
        end else begin
            pd_len <= pd_len + 1'b1;
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_nop_cmd;
        !o_cs_n && o_act_n && o_ras_n && o_cas_n && o_we_n;
    endsequence

    sequence s_des_hold;
        o_cs_n [*8];
    endsequence

    a_pde_deselect: assert property (
        ($fell(o_cke) && r.st == ST_PDE) |-> s_des_hold
    ) else $error("deselect not held after enable fall");

    a_cke_low_min: assert property (
        $fell(o_cke) |-> !o_cke [*8]
    ) else $error("enable low shorter than minimum");

    a_cke_high_min: assert property (
        $rose(o_cke) |-> o_cke [*8]
    ) else $error("enable high shorter than minimum");

    a_busy_blocks: assert property (
        $fell(o_cke) |-> !$past(i_dev_busy)
    ) else $error("enable dropped while memory busy");

    a_nop_window: assert property (
        (r.st == ST_SRXL) |-> s_nop_cmd
    ) else $error("non no-op command in low hold window");

    a_lh_bound: assert property (
        ($rose(o_cke) && r.st == ST_SRXL) |-> !o_cs_n ##[LH_LO:LH_HI] $rose(o_cs_n)
    ) else $error("select low hold out of bounds");

    a_pd_limit: assert property (
        pd_len < TMR_W'(PD_LIM)
    ) else $error("power-down held too long");

    a_reset_held: assert property (
        in_pd |-> o_reset_n
    ) else $error("reset dropped during power-down");

    a_nop_exit_clean: assert property (
        (r.st == ST_SRXS) |-> (r.lat_pc == 2'h0) && r.mode[MB_SHARED]
    ) else $error("no-op exit with parity or latency set");

    a_exit_wait: assert property (
        ($rose(o_cke) && r.st == ST_PDX) |-> s_des_hold
    ) else $error("command before exit latency");

    a_rate_frozen: assert property (
        (in_sr && $past(in_sr)) |-> $stable(r.mode[1:0])
    ) else $error("rate mode changed during self-refresh");

endmodule

// [tb/lpc_mem_model.sv]
`timescale 1ns/1ps
module lpc_mem_model
    import lpc_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_ck,
    input  wire logic       i_cke,
    input  wire logic       i_cs_n,
    input  wire logic       i_act_n,
    input  wire logic       i_ras_n,
    input  wire logic       i_cas_n,
    input  wire logic       i_we_n,
    input  wire logic       i_reset_n,
    input  wire logic [1:0] i_rate,
    input  wire logic       i_burst,
    output logic            o_busy,
    output logic [7:0]      o_viol
);
    logic       ck_r = 1'b0;
    logic       cke_r = 1'b1;
    logic       cke_raw_r = 1'b1;
    logic       pd_r = 1'b0;
    logic       sr_r = 1'b0;
    logic       lh_r = 1'b0;
    logic       hot_r = 1'b0;
    logic [1:0] rate_r = 2'h0;
    logic [1:0] rate_eff;
    logic [7:0] busy_r = 8'h00;
    logic [7:0] lh_cnt_r = 8'h00;
    logic       nop;
    logic       des;
    logic       sre;

    assign nop = !i_cs_n && i_act_n && i_ras_n && i_cas_n && i_we_n;
    assign des = i_cs_n;
    assign sre = !i_cs_n && i_act_n && !i_ras_n && !i_cas_n && i_we_n;
    assign o_busy = (busy_r != 8'h00);
    // Auto mode follows a crude two-level temperature; manual modes stay fixed.
    assign rate_eff = (rate_r == 2'h3) ? (hot_r ? 2'h2 : 2'h1) : rate_r;
    initial o_viol = 8'h00;

    always @(posedge i_ref_clk) begin
        ck_r <= i_ck;
        cke_raw_r <= i_cke;
        busy_r <= i_burst ? 8'h28 : (o_busy ? busy_r - 8'h01 : busy_r);
        // A reset that raises the enable is not an exit, so no hold window starts.
        if (sr_r && i_reset_n && !cke_raw_r && i_cke) begin
            lh_r <= 1'b1;
            lh_cnt_r <= 8'h00;
        end else if (lh_r && i_cs_n) begin
            lh_r <= 1'b0;
            if (lh_cnt_r < LH_MIN_CYC || lh_cnt_r > LH_MAX_CYC_I) o_viol <= o_viol + 8'h01;
        end else if (lh_r) begin
            lh_cnt_r <= lh_cnt_r + 8'h01;
        end
        if (i_ck && !ck_r) begin
            cke_r <= i_cke;
            if (!i_reset_n) begin
                pd_r <= 1'b0;
                sr_r <= 1'b0;
            end else if (cke_r && !i_cke) begin
                if (o_busy) o_viol <= o_viol + 8'h01;
                if (sre) begin
                    sr_r <= 1'b1;
                    rate_r <= i_rate;
                    hot_r <= ~hot_r;
                end else if (des) begin
                    pd_r <= 1'b1;
                end else begin
                    o_viol <= o_viol + 8'h01;
                end
            end else if (!cke_r && i_cke) begin
                if (!(des || (sr_r && nop))) o_viol <= o_viol + 8'h01;
                pd_r <= 1'b0;
                sr_r <= 1'b0;
            end else if (lh_r && !nop) begin
                o_viol <= o_viol + 8'h01;
            end
        end
    end
endmodule

// [tb/lpc_host_tb_top.sv]
`timescale 1ns/1ps
module lpc_host_tb_top
    import lpc_pkg::*;
;
    typedef struct packed {logic [31:0] exp; logic [31:0] msk;} lpc_note_t;
    localparam logic [31:0] SM = 32'h0103_01ff;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic        rd_s = 1'b0;
    logic        wr_s = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic        wreq;
    logic        busy;
    logic        burst = 1'b0;
    logic        ck, cke, cs_n, act_n, ras_n, cas_n, we_n, reset_n, term, term_oe_n, a6, a7, auto;
    logic [7:0]  viol;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          seed = 32'hfde9;
    lpc_note_t   notes[$];
    lpc_note_t   nt;

    lpc_host #(.CK_HALF(4)) lpc_host_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr),
        .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_dev_busy(busy), .o_ck(ck),
        .o_cke(cke), .o_cs_n(cs_n), .o_act_n(act_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
        .o_we_n(we_n), .o_reset_n(reset_n), .o_term(term), .o_term_oe_n(term_oe_n),
        .o_rate_a6(a6), .o_rate_a7(a7), .o_auto_rate(auto));
    lpc_mem_model lpc_mem_model_i (.i_ref_clk(clk), .i_ck(ck), .i_cke(cke), .i_cs_n(cs_n),
        .i_act_n(act_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_reset_n(reset_n),
        .i_rate({a7, a6}), .i_burst(burst), .o_busy(busy), .o_viol(viol));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Called right after a rising edge; returns one edge after the release.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wr_s <= w;
        rd_s <= !w;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (n >= 20) begin
            chk("waitrequest", 32'h0, 32'h1);
            tally_and_finish();
        end
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e, m});
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wait_cke(input logic v, input int lim);
        int n;
        n = 0;
        while (cke !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            chk("cke_wait", {31'h0, v}, {31'h0, cke});
            tally_and_finish();
        end
    endtask

    function automatic logic [31:0] stv(lpc_state_t s, logic k, logic [1:0] e);
        stv = {23'h0, s};
        stv[SB_CKE] = k;
        stv[SB_ERR_REF] = e[0];
        stv[SB_ERR_PDTO] = e[1];
    endfunction

    always @(posedge clk) begin
        if (rd_s === 1'b1 && wreq === 1'b0) begin
            if (notes.size() == 0) begin
                chk("note_queue", 32'h1, 32'h0);
            end else begin
                nt = notes.pop_front();
                chk("readdata", nt.exp & nt.msk, rdata & nt.msk);
            end
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(ADDR_MODE, {24'h0, MODE_RST}, 32'h0000_00ff);
        rd(ADDR_STATUS, stv(ST_IDLE, 1'b1, 2'h0), SM);
        bus(1'b1, 4'hc, $random(seed));
        rd(4'hc, 32'h0000_0000, 32'hffff_ffff);
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, ADDR_MODE, 32'h0000_0080 | r);
            chk("rate_pins", 32'(r) | ((r == 3) ? 4 : 0), {29'h0, auto, a7, a6});
        end
        for (int t = 0; t < 2; t++) begin
            bus(1'b1, ADDR_MODE, 32'h0000_0080 | (t << 2) | ($random(seed) & 3));
            burst <= 1'b1;
            @(posedge clk);
            burst <= 1'b0;
            bus(1'b1, ADDR_CMD, 32'h0000_0001);
            rd(ADDR_STATUS, 32'h0104_0000, 32'h011c_0000);
            wait_cke(1'b0, 200);
            repeat (16) @(posedge clk);
            rd(ADDR_STATUS, stv(ST_PD, 1'b0, 2'h0), SM);
            chk("term_oe_n_pd", t, {31'h0, term_oe_n});
            chk("reset_n_pd", 32'h1, {31'h0, reset_n});
            bus(1'b1, ADDR_CMD, 32'h0000_0002);
            wait_cke(1'b1, 200);
            repeat (16) @(posedge clk);
            rd(ADDR_STATUS, stv(ST_IDLE, 1'b1, 2'h0), SM);
            chk("term_oe_n_exit", 32'h0, {31'h0, term_oe_n});
            chk("term_exit", 32'h0, {31'h0, term});
        end
        bus(1'b1, ADDR_CMD, 32'h0000_0001);
        wait_cke(1'b0, 200);
        wait_cke(1'b1, PD_REFI_LIMIT * T_REFI_NS / REF_PERIOD_NS);
        repeat (16) @(posedge clk);
        rd(ADDR_STATUS, stv(ST_IDLE, 1'b1, 2'h2), SM);
        bus(1'b1, ADDR_STATUS, 32'h0002_0000);
        rd(ADDR_STATUS, stv(ST_IDLE, 1'b1, 2'h0), SM);
        bus(1'b1, ADDR_MODE, 32'h0000_00c1);
        bus(1'b1, ADDR_CMD, 32'h0000_0003);
        wait_cke(1'b0, 100);
        // Entry needs one more link period before the refresh state is settled.
        repeat (16) @(posedge clk);
        bus(1'b1, ADDR_MODE, 32'h0000_00c2);
        rd(ADDR_STATUS, stv(ST_SR, 1'b0, 2'h1), SM);
        chk("rate_kept", 32'h1, {30'h0, a7, a6});
        bus(1'b1, ADDR_STATUS, 32'h0001_0000);
        bus(1'b1, ADDR_CMD, 32'h0000_0004);
        wait_cke(1'b1, 100);
        repeat (XS_CYC + 32) @(posedge clk);
        rd(ADDR_STATUS, stv(ST_IDLE, 1'b1, 2'h0), SM);
        bus(1'b1, ADDR_MODE, 32'h0000_00d0);
        bus(1'b1, ADDR_CMD, 32'h0000_0003);
        wait_cke(1'b0, 100);
        repeat (16) @(posedge clk);
        bus(1'b1, ADDR_CMD, 32'h0000_0004);
        repeat (32) @(posedge clk);
        rd(ADDR_STATUS, stv(ST_SR, 1'b0, 2'h1), SM);
        rst_b <= 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(ADDR_STATUS, stv(ST_IDLE, 1'b1, 2'h0), SM);
        rd(ADDR_MODE, {24'h0, MODE_RST}, 32'h0000_00ff);
        chk("model_viol", 32'h0, {24'h0, viol});
        tally_and_finish();
    end
endmodule
